/* File: suspend_resume_sequencer_defines.svh */
`ifndef SUSPEND_RESUME_SEQUENCER_DEFINES_SVH
`define SUSPEND_RESUME_SEQUENCER_DEFINES_SVH

// Core clock period and slow tick period, in ns
`define SRS_CLK_PERIOD_NS    4
`define SRS_TICK_PERIOD_NS   32000
// Tick period in core cycles, rounded down
`define SRS_TICK_CYCLES      (`SRS_TICK_PERIOD_NS / `SRS_CLK_PERIOD_NS)

// PLL lock wait and status hold, in ns
`define SRS_PLL_LOCK_NS      16000000
`define SRS_STATUS_HOLD_NS   1000000
// Least times, rounded up to whole ticks
`define SRS_PLL_LOCK_TICKS   ((`SRS_PLL_LOCK_NS + `SRS_TICK_PERIOD_NS - 1) / `SRS_TICK_PERIOD_NS)
`define SRS_STATUS_TICKS     ((`SRS_STATUS_HOLD_NS + `SRS_TICK_PERIOD_NS - 1) / `SRS_TICK_PERIOD_NS)

// Synchroniser vector layout
`define SRS_SYNC_W           8
`define SRS_BIT_SUSP_REQ     0
`define SRS_BIT_STR_SEL      1
`define SRS_BIT_RESUME       2
`define SRS_BIT_MODE_LO      3
`define SRS_BIT_MODE_HI      4
`define SRS_BIT_CLK_CTRL     5
`define SRS_BIT_STOP_GRANT   6
`define SRS_BIT_POWER_GOOD   7

`endif

/* File: suspend_resume_sequencer_pkg.sv */
package suspend_resume_sequencer_pkg;

	typedef enum logic [3:0] {
		ST_ON       = 4'h0,
		ST_E_HALT   = 4'h1,
		ST_E_GRANT  = 4'h2,
		ST_E_STAT   = 4'h3,
		ST_E_CSTOP  = 4'h4,
		ST_E_PLANE  = 4'h5,
		ST_POS      = 4'h6,
		ST_STR      = 4'h7,
		ST_OFF      = 4'h8,
		ST_R_EVT    = 4'h9,
		ST_R_WAIT   = 4'ha,
		ST_R_STAT   = 4'hb,
		ST_R_POST_A = 4'hc,
		ST_R_POST_B = 4'hd
	} seq_state_t;

	typedef enum logic [1:0] {
		RM_FULL_RESET = 2'h0,
		RM_CPU_RESET  = 2'h1,
		RM_NO_RESET   = 2'h2
	} resume_mode_t;

endpackage

/* File: rtc_tick_gen.sv */
module rtc_tick_gen #(
	parameter int unsigned PERIOD_CYCLES = 8000
) (
	input  wire logic CORE_CLK,
	input  wire logic RSTN,
	output logic      TICK
);
	logic [15:0] cnt_ff;

	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			cnt_ff <= 16'h0000;
		end else if (cnt_ff == 16'(PERIOD_CYCLES - 1)) begin
			cnt_ff <= 16'h0000;
		end else begin
			cnt_ff <= cnt_ff + 16'h0001;
		end
	end

	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			TICK <= 1'b0;
		end else begin
			TICK <= (cnt_ff == 16'(PERIOD_CYCLES - 1));
		end
	end
endmodule

/* File: suspend_resume_sequencer.sv */
`include "suspend_resume_sequencer_defines.svh"

// Operation
// - Every sequence step except taking the resume event is paced by an internal tick of about 32 us.
// - Resume from power-on-suspend releases plane A at least one tick after event.
// - Full-reset resume asserts PCI and processor resets at least one tick after event.
// - Reset-type resumes release sleep and clock halt at least one tick after event.
// - Clock-halt requests release at least 16 ms after plane A release.
// - Release also needs power good, held at least one tick.
// - Suspend status releases at least 1 ms after clock-halt release.
// - Full-reset resume releases PCI reset within one tick of status release.
// - Full-reset resume releases processor reset within one tick after PCI reset.
// - Full-reset resume frees clock-halt requests at least 1 ms before PCI reset release.
// - Processor-reset resume keeps PCI reset, releases processor reset within one tick of status release.
// - Other resumes also free clock-halt requests at least 1 ms before status release.
// - No-reset resume releases sleep within one tick, clock halt one tick later.
// - Suspend entry asserts clock halt at least one tick after requests inactive.
// - Sleep asserts at least one tick after clock halt, after stop grant.
// - Status asserts within a tick of sleep; halt requests within a further tick.
// - Suspend-to-RAM asserts planes A and B within one tick after halt step.
// - In suspend-to-RAM, within a tick of power good loss: float, resets on, sleep, halt off.
// - With power good held, suspend-to-RAM outputs stay where they were.
module suspend_resume_sequencer #(
	parameter int unsigned TICK_CYCLES = `SRS_TICK_CYCLES,
	parameter int unsigned PLL_TICKS   = `SRS_PLL_LOCK_TICKS,
	parameter int unsigned STAT_TICKS  = `SRS_STATUS_TICKS
) (
	input  wire logic       CORE_CLK,
	input  wire logic       RSTN,
	input  wire logic       SUSPEND_REQ,
	input  wire logic       SUSPEND_TO_RAM_SEL,
	input  wire logic       RESUME_EVENT,
	input  wire logic [1:0] RESUME_MODE,
	input  wire logic       CLOCK_CONTROL_EN,
	input  wire logic       STOP_GRANT,
	input  wire logic       POWER_GOOD,
	output logic [1:0]      SUSPEND_PLANES_AB_N,
	output logic [1:0]      SUSPEND_STATE_OUT_N,
	output logic            PCI_BUS_RESET_OUT_N,
	output logic            PROCESSOR_RESET,
	output logic            PROCESSOR_SLEEP_N,
	output logic            PROCESSOR_CLOCK_HALT_N,
	output logic            PCI_CLOCK_HALT_REQ_N,
	output logic            PCI_CLOCK_HALT_REQ_OE_N,
	output logic            PROCESSOR_CLOCK_HALT_REQ_N,
	output logic            PROCESSOR_CLOCK_HALT_REQ_OE_N,
	output logic            SUSPEND_TO_RAM_STATE
);
	logic [`SRS_SYNC_W-1:0]                      sync1_ff;
	logic [`SRS_SYNC_W-1:0]                      sync2_ff;
	logic                                        tick;
	suspend_resume_sequencer_pkg::seq_state_t    state_ff;
	suspend_resume_sequencer_pkg::seq_state_t    nxt_state;
	suspend_resume_sequencer_pkg::resume_mode_t  mode_ff;
	logic [15:0]                                 tcnt_ff;
	logic [1:0]                                  pg_ticks_ff;
	logic                                        halt_req_n_ff;
	logic                                        halt_oe_n_ff;
	logic                                        go;
	logic                                        susp_req;
	logic                                        str_sel;
	logic                                        resume;
	logic                                        clk_ctrl;
	logic                                        grant;
	logic                                        pg;

	// True on a tick once at least n ticks have passed since state entry
	function automatic logic due(input logic t, input logic [15:0] cnt, input logic [15:0] n);
		due = t && (cnt >= n);
	endfunction

	// Every input pin but the clock and reset passes two flops before use
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end else begin
			sync1_ff <= {POWER_GOOD, STOP_GRANT, CLOCK_CONTROL_EN, RESUME_MODE,
				RESUME_EVENT, SUSPEND_TO_RAM_SEL, SUSPEND_REQ};
			sync2_ff <= sync1_ff;
		end
	end

	assign susp_req = sync2_ff[`SRS_BIT_SUSP_REQ];
	assign str_sel  = sync2_ff[`SRS_BIT_STR_SEL];
	assign resume   = sync2_ff[`SRS_BIT_RESUME];
	assign clk_ctrl = sync2_ff[`SRS_BIT_CLK_CTRL];
	assign grant    = sync2_ff[`SRS_BIT_STOP_GRANT];
	assign pg       = sync2_ff[`SRS_BIT_POWER_GOOD];

	rtc_tick_gen #(
		.PERIOD_CYCLES(TICK_CYCLES)
	) u_tick (
		.CORE_CLK(CORE_CLK),
		.RSTN    (RSTN),
		.TICK    (tick)
	);

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			suspend_resume_sequencer_pkg::ST_ON: begin
				if (susp_req && tick) begin
					nxt_state = suspend_resume_sequencer_pkg::ST_E_HALT;
				end
			end
			suspend_resume_sequencer_pkg::ST_E_HALT: begin
				if (due(tick, tcnt_ff, 16'h0001)) begin
					nxt_state = suspend_resume_sequencer_pkg::ST_E_GRANT;
				end
			end
			suspend_resume_sequencer_pkg::ST_E_GRANT: begin
				if (grant && due(tick, tcnt_ff, 16'h0001)) begin
					nxt_state = suspend_resume_sequencer_pkg::ST_E_STAT;
				end
			end
			suspend_resume_sequencer_pkg::ST_E_STAT: begin
				if (tick) begin
					nxt_state = suspend_resume_sequencer_pkg::ST_E_CSTOP;
				end
			end
			suspend_resume_sequencer_pkg::ST_E_CSTOP: begin
				if (tick) begin
					nxt_state = suspend_resume_sequencer_pkg::ST_E_PLANE;
				end
			end
			suspend_resume_sequencer_pkg::ST_E_PLANE: begin
				if (tick && str_sel) begin
					nxt_state = suspend_resume_sequencer_pkg::ST_STR;
				end else if (tick) begin
					nxt_state = suspend_resume_sequencer_pkg::ST_POS;
				end
			end
			suspend_resume_sequencer_pkg::ST_POS: begin
				if (resume) begin
					nxt_state = suspend_resume_sequencer_pkg::ST_R_EVT;
				end
			end
			suspend_resume_sequencer_pkg::ST_STR: begin
				if (!pg && tick) begin
					nxt_state = suspend_resume_sequencer_pkg::ST_OFF;
				end
			end
			suspend_resume_sequencer_pkg::ST_OFF: begin
				nxt_state = suspend_resume_sequencer_pkg::ST_OFF;
			end
			suspend_resume_sequencer_pkg::ST_R_EVT: begin
				if (due(tick, tcnt_ff, 16'h0001)) begin
					nxt_state = suspend_resume_sequencer_pkg::ST_R_WAIT;
				end
			end
			suspend_resume_sequencer_pkg::ST_R_WAIT: begin
				if (due(tick, tcnt_ff, 16'(PLL_TICKS)) && pg_ticks_ff != 2'h0) begin
					nxt_state = suspend_resume_sequencer_pkg::ST_R_STAT;
				end
			end
			suspend_resume_sequencer_pkg::ST_R_STAT: begin
				if (due(tick, tcnt_ff, 16'(STAT_TICKS))) begin
					nxt_state = suspend_resume_sequencer_pkg::ST_R_POST_A;
				end
			end
			suspend_resume_sequencer_pkg::ST_R_POST_A: begin
				if (tick && mode_ff == suspend_resume_sequencer_pkg::RM_CPU_RESET) begin
					nxt_state = suspend_resume_sequencer_pkg::ST_ON;
				end else if (tick) begin
					nxt_state = suspend_resume_sequencer_pkg::ST_R_POST_B;
				end
			end
			suspend_resume_sequencer_pkg::ST_R_POST_B: begin
				if (tick) begin
					nxt_state = suspend_resume_sequencer_pkg::ST_ON;
				end
			end
			default: begin
				nxt_state = suspend_resume_sequencer_pkg::ST_ON;
			end
		endcase
	end

	assign go = (nxt_state != state_ff);

	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			state_ff <= suspend_resume_sequencer_pkg::ST_ON;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Ticks seen since the current state was entered
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			tcnt_ff <= 16'h0000;
		end else if (go) begin
			tcnt_ff <= 16'h0000;
		end else if (tick && tcnt_ff != 16'hffff) begin
			tcnt_ff <= tcnt_ff + 16'h0001;
		end
	end

	// Ticks seen with power good high, saturating
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			pg_ticks_ff <= 2'h0;
		end else if (!pg) begin
			pg_ticks_ff <= 2'h0;
		end else if (tick && pg_ticks_ff != 2'h3) begin
			pg_ticks_ff <= pg_ticks_ff + 2'h1;
		end
	end

	// Variant is sampled when the resume event is taken
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			mode_ff <= suspend_resume_sequencer_pkg::RM_FULL_RESET;
		end else if (go && state_ff == suspend_resume_sequencer_pkg::ST_POS) begin
			// Unused code 3 folds into the no-reset variant
			if (sync2_ff[`SRS_BIT_MODE_HI:`SRS_BIT_MODE_LO] == 2'h3) begin
				mode_ff <= suspend_resume_sequencer_pkg::RM_NO_RESET;
			end else begin
				mode_ff <= suspend_resume_sequencer_pkg::resume_mode_t'(
					sync2_ff[`SRS_BIT_MODE_HI:`SRS_BIT_MODE_LO]);
			end
		end
	end

	// Output moves happen on the tick that leaves a state
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			SUSPEND_PLANES_AB_N    <= 2'h3;
			SUSPEND_STATE_OUT_N    <= 2'h3;
			PCI_BUS_RESET_OUT_N    <= 1'b1;
			PROCESSOR_RESET        <= 1'b0;
			PROCESSOR_SLEEP_N      <= 1'b1;
			PROCESSOR_CLOCK_HALT_N <= 1'b1;
			halt_req_n_ff          <= 1'b1;
			halt_oe_n_ff           <= 1'b0;
		end else if (go) begin
			case (state_ff)
				suspend_resume_sequencer_pkg::ST_E_HALT: begin
					PROCESSOR_CLOCK_HALT_N <= 1'b0;
				end
				suspend_resume_sequencer_pkg::ST_E_GRANT: begin
					PROCESSOR_SLEEP_N <= 1'b0;
				end
				suspend_resume_sequencer_pkg::ST_E_STAT: begin
					SUSPEND_STATE_OUT_N <= 2'h0;
				end
				suspend_resume_sequencer_pkg::ST_E_CSTOP: begin
					halt_req_n_ff <= !clk_ctrl;
				end
				suspend_resume_sequencer_pkg::ST_E_PLANE: begin
					SUSPEND_PLANES_AB_N <= str_sel ? 2'h0 : 2'h2;
				end
				suspend_resume_sequencer_pkg::ST_STR: begin
					halt_oe_n_ff           <= 1'b1;
					PCI_BUS_RESET_OUT_N    <= 1'b0;
					PROCESSOR_RESET        <= 1'b1;
					PROCESSOR_SLEEP_N      <= 1'b1;
					PROCESSOR_CLOCK_HALT_N <= 1'b1;
				end
				suspend_resume_sequencer_pkg::ST_R_EVT: begin
					SUSPEND_PLANES_AB_N[0] <= 1'b1;
					if (mode_ff == suspend_resume_sequencer_pkg::RM_FULL_RESET) begin
						PCI_BUS_RESET_OUT_N <= 1'b0;
					end
					if (mode_ff != suspend_resume_sequencer_pkg::RM_NO_RESET) begin
						PROCESSOR_RESET        <= 1'b1;
						PROCESSOR_SLEEP_N      <= 1'b1;
						PROCESSOR_CLOCK_HALT_N <= 1'b1;
					end
				end
				suspend_resume_sequencer_pkg::ST_R_WAIT: begin
					halt_req_n_ff <= 1'b1;
				end
				suspend_resume_sequencer_pkg::ST_R_STAT: begin
					SUSPEND_STATE_OUT_N <= 2'h3;
				end
				suspend_resume_sequencer_pkg::ST_R_POST_A: begin
					if (mode_ff == suspend_resume_sequencer_pkg::RM_FULL_RESET) begin
						PCI_BUS_RESET_OUT_N <= 1'b1;
					end else if (mode_ff == suspend_resume_sequencer_pkg::RM_CPU_RESET) begin
						PROCESSOR_RESET <= 1'b0;
					end else begin
						PROCESSOR_SLEEP_N <= 1'b1;
					end
				end
				suspend_resume_sequencer_pkg::ST_R_POST_B: begin
					if (mode_ff == suspend_resume_sequencer_pkg::RM_FULL_RESET) begin
						PROCESSOR_RESET <= 1'b0;
					end else begin
						PROCESSOR_CLOCK_HALT_N <= 1'b1;
					end
				end
				default: begin
					halt_oe_n_ff <= halt_oe_n_ff;
				end
			endcase
		end
	end

	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			SUSPEND_TO_RAM_STATE <= 1'b0;
		end else begin
			SUSPEND_TO_RAM_STATE <= (nxt_state == suspend_resume_sequencer_pkg::ST_STR) ||
				(nxt_state == suspend_resume_sequencer_pkg::ST_OFF);
		end
	end

	// Both clock-halt requests share one driver and one enable
	assign PCI_CLOCK_HALT_REQ_N          = halt_req_n_ff;
	assign PROCESSOR_CLOCK_HALT_REQ_N    = halt_req_n_ff;
	assign PCI_CLOCK_HALT_REQ_OE_N       = halt_oe_n_ff;
	assign PROCESSOR_CLOCK_HALT_REQ_OE_N = halt_oe_n_ff;
endmodule

/* File: srs_assertions.sv */
module srs_checker #(
	parameter int unsigned TICK_CYCLES = 4,
	parameter int unsigned PLL_TICKS   = 3,
	parameter int unsigned STAT_TICKS  = 2
) (
	input wire logic       CORE_CLK,
	input wire logic       RSTN,
	input wire logic       RESUME_EVENT,
	input wire logic       CLOCK_CONTROL_EN,
	input wire logic       POWER_GOOD,
	input wire logic [1:0] SUSPEND_PLANES_AB_N,
	input wire logic [1:0] SUSPEND_STATE_OUT_N,
	input wire logic       PCI_BUS_RESET_OUT_N,
	input wire logic       PROCESSOR_RESET,
	input wire logic       PROCESSOR_SLEEP_N,
	input wire logic       PROCESSOR_CLOCK_HALT_N,
	input wire logic       PCI_CLOCK_HALT_REQ_N,
	input wire logic       PCI_CLOCK_HALT_REQ_OE_N,
	input wire logic       PROCESSOR_CLOCK_HALT_REQ_N,
	input wire logic       SUSPEND_TO_RAM_STATE
);
	localparam int tk = TICK_CYCLES;
	localparam int tk2 = 2 * TICK_CYCLES;
	localparam int pllc = PLL_TICKS * TICK_CYCLES;
	localparam int statc = STAT_TICKS * TICK_CYCLES;
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RSTN);
	sequence stat_fell;
		$fell(SUSPEND_STATE_OUT_N[0]);
	endsequence
	sequence pg_lost;
		$fell(POWER_GOOD) && SUSPEND_TO_RAM_STATE;
	endsequence
	halt_pair_a: assert property (PCI_CLOCK_HALT_REQ_N == PROCESSOR_CLOCK_HALT_REQ_N &&
		(PCI_CLOCK_HALT_REQ_N || PCI_CLOCK_HALT_REQ_OE_N || SUSPEND_STATE_OUT_N == 2'h0))
		else $error("halt requests differ or lead status");
	sleep_order_a: assert property ($fell(PROCESSOR_SLEEP_N) |->
		!$past(PROCESSOR_CLOCK_HALT_N, tk) ##tk stat_fell) else $error("sleep out of order");
	req_step_a: assert property (stat_fell ##0 CLOCK_CONTROL_EN |->
		##tk $fell(PCI_CLOCK_HALT_REQ_N)) else $error("halt request step late");
	plane_step_a: assert property (stat_fell |-> ##tk2 $fell(SUSPEND_PLANES_AB_N[0]))
		else $error("plane step late");
	resume_plane_a: assert property ($rose(SUSPEND_PLANES_AB_N[0]) |->
		$past(RESUME_EVENT, tk)) else $error("plane released too early");
	halt_release_a: assert property ($rose(PCI_CLOCK_HALT_REQ_N) && !PCI_CLOCK_HALT_REQ_OE_N |->
		$past(SUSPEND_PLANES_AB_N[0], pllc) && $past(POWER_GOOD, tk)) else $error("halt release early");
	status_release_a: assert property ($rose(SUSPEND_STATE_OUT_N[0]) |->
		$past(PCI_CLOCK_HALT_REQ_N, statc)) else $error("status released early");
	pci_release_a: assert property ($rose(PCI_BUS_RESET_OUT_N) |->
		$past(SUSPEND_STATE_OUT_N[0], tk) && !$past(SUSPEND_STATE_OUT_N[0], tk + 1))
		else $error("bus reset release mistimed");
	cpu_release_a: assert property ($fell(PROCESSOR_RESET) |->
		PCI_BUS_RESET_OUT_N && $past(SUSPEND_STATE_OUT_N[0], tk)) else $error("cpu reset early");
	power_loss_a: assert property (pg_lost |-> ##[1:8] (PCI_CLOCK_HALT_REQ_OE_N &&
		!PCI_BUS_RESET_OUT_N && PROCESSOR_RESET && PROCESSOR_SLEEP_N && PROCESSOR_CLOCK_HALT_N))
		else $error("power loss outputs late");
	str_hold_a: assert property (SUSPEND_TO_RAM_STATE && $past(SUSPEND_PLANES_AB_N) == 2'h0 &&
		POWER_GOOD && $past(POWER_GOOD) && $past(POWER_GOOD, 2) && $past(POWER_GOOD, 3) |->
		$stable(PROCESSOR_SLEEP_N) && $stable(PCI_CLOCK_HALT_REQ_OE_N)) else $error("state moved");
endmodule

bind suspend_resume_sequencer srs_checker #(
	.TICK_CYCLES(TICK_CYCLES),
	.PLL_TICKS(PLL_TICKS),
	.STAT_TICKS(STAT_TICKS)
) u_chk (
	.CORE_CLK, .RSTN, .RESUME_EVENT, .CLOCK_CONTROL_EN, .POWER_GOOD,
	.SUSPEND_PLANES_AB_N, .SUSPEND_STATE_OUT_N, .PCI_BUS_RESET_OUT_N, .PROCESSOR_RESET,
	.PROCESSOR_SLEEP_N, .PROCESSOR_CLOCK_HALT_N, .PCI_CLOCK_HALT_REQ_N,
	.PCI_CLOCK_HALT_REQ_OE_N, .PROCESSOR_CLOCK_HALT_REQ_N, .SUSPEND_TO_RAM_STATE
);

/* File: srs_partner.sv */
module srs_partner (
	input  wire logic       clk,
	input  wire logic       halt_n,
	input  wire logic       halt_req_n,
	input  wire logic       supply_on,
	input  wire logic [7:0] grant_dly,
	output logic            stop_grant,
	output logic            power_good
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt_ff = 8'h00;
	logic       clk_run_ff = 1'b1;
	// Synthesizer starts or stops both clocks one cycle after the halt requests move
	always_ff @(posedge clk) begin
		clk_run_ff <= halt_req_n;
	end
	// Processor finishes its stop-grant cycle grant_dly cycles after clock halt asserts
	always_ff @(posedge clk) begin
		cnt_ff <= halt_n ? 8'h00 : ((cnt_ff < grant_dly) ? cnt_ff + 8'h01 : cnt_ff);
	end
	// Stop-grant cycle needs a running clock
	assign stop_grant = clk_run_ff && !halt_n && (cnt_ff >= grant_dly);
	// Supply only drops power good once the bench removes power
	assign power_good = supply_on;
endmodule

/* File: tb_top.sv */
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int          tk = 4;
	localparam int          pll = 3;
	localparam int          stat_t = 2;
	localparam logic [10:0] idle = 11'h7dc;
	localparam logic [10:0] exp_a [4] = '{11'h638, 11'h678, 11'h640, 11'h640};
	localparam logic [10:0] step_b [4] = '{11'h7fc, 11'h7dc, 11'h7d4, 11'h7d4};
	logic        core_clk = 1'b0;
	logic        rstn = 1'b0;
	logic        susp_req = 1'b0;
	logic        str_sel = 1'b0;
	logic        resume_ev = 1'b0;
	logic [1:0]  mode = 2'h0;
	logic        clk_ctrl = 1'b1;
	logic        supply_on = 1'b1;
	logic [7:0]  grant_dly = 8'h00;
	logic        stop_grant;
	logic        power_good;
	logic [1:0]  planes_n;
	logic [1:0]  stat_n;
	logic        pci_rst_n;
	logic        cpu_rst;
	logic        sleep_n;
	logic        halt_n;
	logic        req_n;
	logic        oe_n;
	logic        req2_n;
	logic        oe2_n;
	logic        str;
	logic [10:0] outs;
	int          bad_count = 0;
	int          n_compared = 0;

	assign outs = {planes_n, stat_n, pci_rst_n, cpu_rst, sleep_n, halt_n, req_n, oe_n, str};
	always #2 core_clk = ~core_clk;

	suspend_resume_sequencer #(.TICK_CYCLES(tk), .PLL_TICKS(pll), .STAT_TICKS(stat_t)) u_dut (
		.CORE_CLK(core_clk), .RSTN(rstn), .SUSPEND_REQ(susp_req),
		.SUSPEND_TO_RAM_SEL(str_sel), .RESUME_EVENT(resume_ev), .RESUME_MODE(mode),
		.CLOCK_CONTROL_EN(clk_ctrl), .STOP_GRANT(stop_grant), .POWER_GOOD(power_good),
		.SUSPEND_PLANES_AB_N(planes_n), .SUSPEND_STATE_OUT_N(stat_n),
		.PCI_BUS_RESET_OUT_N(pci_rst_n), .PROCESSOR_RESET(cpu_rst),
		.PROCESSOR_SLEEP_N(sleep_n), .PROCESSOR_CLOCK_HALT_N(halt_n),
		.PCI_CLOCK_HALT_REQ_N(req_n), .PCI_CLOCK_HALT_REQ_OE_N(oe_n),
		.PROCESSOR_CLOCK_HALT_REQ_N(req2_n), .PROCESSOR_CLOCK_HALT_REQ_OE_N(oe2_n),
		.SUSPEND_TO_RAM_STATE(str)
	);
	srs_partner u_far (
		.clk(core_clk), .halt_n(halt_n), .halt_req_n(req_n), .supply_on(supply_on),
		.grant_dly(grant_dly),
		.stop_grant(stop_grant), .power_good(power_good)
	);

	task automatic chk(input logic [10:0] got, input logic [10:0] exp);
		n_compared++;
		if (got !== exp || {req2_n, oe2_n} !== {req_n, oe_n}) begin
			bad_count++;
			$display("mismatch at %0t: outputs %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_ge(input int got, input int least);
		n_compared++;
		if (got < least) begin
			bad_count++;
			$display("mismatch at %0t: %0d cycles, least %0d", $time, got, least);
		end
	endtask
	task automatic give_verdict();
		$display("comparisons %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic do_reset();
		@(posedge core_clk);
		rstn <= 1'b0;
		supply_on <= 1'b1;
		resume_ev <= 1'b0;
		repeat (3) @(posedge core_clk);
		rstn <= 1'b1;
		cyc(5 * tk);
		chk(outs, idle);
	endtask
	task automatic enter(input logic ram, input logic cc, input logic [7:0] gd,
		input logic [10:0] exp);
		int n;
		@(posedge core_clk);
		str_sel <= ram;
		clk_ctrl <= cc;
		grant_dly <= gd;
		susp_req <= 1'b1;
		for (n = 0; n < 400 && planes_n[0] !== 1'b0; n++) cyc(1);
		@(posedge core_clk);
		susp_req <= 1'b0;
		chk(outs, exp);
		chk_ge(n, int'(gd) + 5 * tk);
	endtask
	task automatic do_resume(input logic [1:0] m, input int pgd);
		int n;
		@(posedge core_clk);
		mode <= m;
		resume_ev <= 1'b1;
		for (n = 0; n < 100 && planes_n[0] !== 1'b1; n++) cyc(1);
		chk(outs, exp_a[m]);
		chk_ge(n, tk);
		repeat (pgd + 1) @(posedge core_clk);
		supply_on <= 1'b1;
		resume_ev <= 1'b0;
		for (n = 0; n < 1000 && req_n !== 1'b1; n++) cyc(1);
		chk(outs, exp_a[m] | 11'h004);
		chk_ge(n, (pgd > 0) ? tk : pll * tk);
		for (n = 0; n < 100 && stat_n !== 2'h3; n++) cyc(1);
		chk(outs, exp_a[m] | 11'h184);
		chk_ge(n, stat_t * tk);
		cyc(tk);
		chk(outs, step_b[m]);
		cyc(tk);
		chk(outs, idle);
	endtask
	task automatic test_str(input logic cc);
		do_reset();
		enter(1'b1, cc, 8'h08, cc ? 11'h041 : 11'h045);
		@(posedge core_clk);
		resume_ev <= 1'b1;
		cyc(10 * tk);
		chk(outs, cc ? 11'h041 : 11'h045);
		@(posedge core_clk);
		resume_ev <= 1'b0;
		supply_on <= 1'b0;
		cyc(2 * tk);
		chk(outs & 11'h7fb, 11'h03b);
		$display("suspend-to-RAM test done, clock control %0d", cc);
	endtask

	initial begin
		for (int m = 0; m < 4; m++) begin
			if (m == 0) do_reset();
			enter(1'b0, 1'b1, 8'(m * 20), 11'h440);
			do_resume(2'(m), 0);
			$display("resume test done, mode %0d", m);
		end
		do_reset();
		enter(1'b0, 1'b1, 8'h00, 11'h440);
		@(posedge core_clk);
		supply_on <= 1'b0;
		do_resume(2'h0, 20 * tk);
		$display("late power good test done");
		test_str(1'b0);
		test_str(1'b1);
		give_verdict();
	end
	initial begin
		#80000;
		bad_count++;
		$display("mismatch at %0t: watchdog expired", $time);
		give_verdict();
	end
endmodule
